// ---- src/mrf_cfg.svh ----
`ifndef MRF_CFG_SVH
`define MRF_CFG_SVH
// ==========================================================
// register byte offsets on the apb window
`define MRF_A_CTRL 8'h00
`define MRF_A_CMD 8'h04
`define MRF_A_STAT 8'h08
`define MRF_A_NPTS 8'h0C
// ==========================================================
// control bits
`define MRF_B_BINARY 0
`define MRF_B_COMP 1
`define MRF_B_LIST 2
`define MRF_B_CONT 3
`define MRF_B_LCOMP 4
// command bits, write-one pulses
`define MRF_C_INIT 0
`define MRF_C_ABORT 1
`define MRF_C_TRIG 2
`define MRF_C_FETCH 3
// status bits
`define MRF_S_HAVE 2
`define MRF_S_BUSY 3
`define MRF_S_ERR 4
// ==========================================================
// reset values and limits
`define MRF_CTRL_RST 5'h00
`define MRF_NPTS_RST 4'h1
`define MRF_MAX_PTS 4'hA
// ==========================================================
// characters
`define MRF_CH_HASH 8'h23
`define MRF_CH_COMMA 8'h2C
`define MRF_CH_LF 8'h0A
`define MRF_CH_PLUS 8'h2B
`define MRF_CH_MINUS 8'h2D
`define MRF_CH_DOT 8'h2E
`define MRF_CH_EXP 8'h45
`define MRF_CH_ZERO 8'h30
`define MRF_CH_NUL 8'h00
// ==========================================================
// field geometry and number constants
`define MRF_ASC_LAST 4'hB
`define MRF_DBL_LAST 4'h7
`define MRF_EXP_BIAS 11'h3FF
`define MRF_OVF_DBL $realtobits(9.9E37)
`define MRF_OVF_DEC 34'h1_3200_0037
`endif

// ---- src/mrf_pkg.sv ----
package mrf_pkg;
  // ==========================================================
  // remote trigger states
  typedef enum logic [1:0] {TR_IDLE, TR_WAIT, TR_MEAS} mrf_trig_t;
  // output sequencer phases
  typedef enum logic [2:0]
  {
    PH_IDLE, PH_HASH, PH_NDIG, PH_LEN, PH_FLD, PH_COMMA, PH_ZERO, PH_LF
  } mrf_phase_t;
  // decimal value: sign, six mantissa digits, exponent sign, two digits
  typedef struct packed {
    logic neg;
    logic [5:0][3:0] mant;
    logic eneg;
    logic [1:0][3:0] expo;
  } mrf_dec_t;
  // whole state of the formatter
  typedef struct packed {
    mrf_trig_t trig;
    logic have;
    logic err;
    logic [4:0] ctrl;
    logic [3:0] npts;
    mrf_phase_t ph;
    logic [3:0] pt;
    logic [1:0] fld;
    logic [3:0] idx;
    logic [7:0] txd;
    logic txv;
    logic txe;
    logic mstart;
    logic [31:0] rdata;
    logic slverr;
  } mrf_st_t;
endpackage : mrf_pkg

// ---- src/mrf_field_char.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "mrf_cfg.svh"
module mrf_field_char
  import mrf_pkg::*;
(
  // selection
  input wire logic BIN_MODE_IN,
  input wire logic [1:0] FSEL_IN,
  input wire logic [3:0] IDX_IN,
  // values of the current point
  input wire logic [33:0] PRI_DEC_IN,
  input wire logic [33:0] SEC_DEC_IN,
  input wire logic [63:0] PRI_DBL_IN,
  input wire logic [63:0] SEC_DBL_IN,
  input wire logic signed [2:0] STATUS_IN,
  input wire logic signed [4:0] AUX_IN,
  // character out
  output logic [7:0] BYTE_OUT,
  output logic LAST_OUT
);
  // ==========================================================
  // helpers
  function automatic logic [7:0] dch(input logic [3:0] d);
    dch = `MRF_CH_ZERO | {4'h0, d};
  endfunction : dch

  // small integer to double, exact for magnitudes up to fifteen
  function automatic logic [63:0] int_dbl(input logic signed [4:0] v);
    logic [3:0] m;
    logic [1:0] p;
    logic [63:0] r;
    m = v[4] ? 4'(-v) : v[3:0];
    p = m[3] ? 2'd3 : (m[2] ? 2'd2 : (m[1] ? 2'd1 : 2'd0));
    r = 64'h0;
    if (m != 4'h0)
    begin
      r[63] = v[4];
      r[62:52] = `MRF_EXP_BIAS + {9'h0, p};
      r[51:0] = {m, 48'h0} << (3'd4 - {1'b0, p});
    end
    int_dbl = r;
  endfunction : int_dbl

  // ==========================================================
  // field character selection
  always_comb
  begin
    logic subst;
    mrf_dec_t dec;
    logic [63:0] dbl;
    logic signed [4:0] iv;
    logic [3:0] mag;
    subst = (STATUS_IN == -3'sd1) || (STATUS_IN == 3'sd1) ||
            (STATUS_IN == 3'sd2);
    dec = (FSEL_IN == 2'd0) ? PRI_DEC_IN : SEC_DEC_IN;
    dbl = (FSEL_IN == 2'd0) ? PRI_DBL_IN : SEC_DBL_IN;
    if (subst)
    begin
      dec = `MRF_OVF_DEC;
      dbl = `MRF_OVF_DBL;
    end
    iv = (FSEL_IN == 2'd2) ? {{2{STATUS_IN[2]}}, STATUS_IN} : AUX_IN;
    mag = iv[4] ? 4'(-iv) : iv[3:0];
    BYTE_OUT = `MRF_CH_NUL;
    LAST_OUT = 1'b0;
    if (BIN_MODE_IN)
    begin
      // sign and high exponent first, lowest fraction bit last
      if (FSEL_IN >= 2'd2)
        dbl = int_dbl(iv);
      BYTE_OUT = dbl[6'(63 - 8 * IDX_IN[2:0]) -: 8];
      LAST_OUT = (IDX_IN == `MRF_DBL_LAST);
    end
    else if (FSEL_IN < 2'd2)
    begin
      // fixed twelve characters, sign, digit, point, five, exponent
      LAST_OUT = (IDX_IN == `MRF_ASC_LAST);
      unique case (IDX_IN)
        4'h0: BYTE_OUT = dec.neg ? `MRF_CH_MINUS : `MRF_CH_PLUS;
        4'h1: BYTE_OUT = dch(dec.mant[5]);
        4'h2: BYTE_OUT = `MRF_CH_DOT;
        4'h8: BYTE_OUT = `MRF_CH_EXP;
        4'h9: BYTE_OUT = dec.eneg ? `MRF_CH_MINUS : `MRF_CH_PLUS;
        4'hA: BYTE_OUT = dch(dec.expo[1]);
        4'hB: BYTE_OUT = dch(dec.expo[0]);
        default: BYTE_OUT = dch(dec.mant[3'(7 - IDX_IN)]);
      endcase
    end
    else
    begin
      // sign then one digit, or two when the value reaches ten
      if (IDX_IN == 4'h0)
        BYTE_OUT = iv[4] ? `MRF_CH_MINUS : `MRF_CH_PLUS;
      else if (mag >= 4'hA)
        BYTE_OUT = (IDX_IN == 4'h1) ? dch(4'h1) : dch(mag - 4'hA);
      else
        BYTE_OUT = dch(mag);
      LAST_OUT = (mag >= 4'hA) ? (IDX_IN == 4'h2) : (IDX_IN == 4'h1);
    end
  end
endmodule : mrf_field_char
`default_nettype wire

// ---- src/mrf_formatter.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "mrf_cfg.svh"
module mrf_formatter
  import mrf_pkg::*;
(
  // clock and reset
  input wire logic MCLK_IN,
  input wire logic RSTN_IN,
  // apb slave
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  // measurement engine
  input wire logic TRIG_IN,
  input wire logic MEAS_DONE_IN,
  output logic MEAS_START_OUT,
  output logic [3:0] PT_IDX_OUT,
  input wire logic [33:0] PRI_DEC_IN,
  input wire logic [33:0] SEC_DEC_IN,
  input wire logic [63:0] PRI_DBL_IN,
  input wire logic [63:0] SEC_DBL_IN,
  input wire logic signed [2:0] STATUS_IN,
  input wire logic [3:0] BIN_IN,
  input wire logic signed [1:0] VERDICT_IN,
  // talker byte stream
  output logic [7:0] TX_DATA_OUT,
  output logic TX_VALID_OUT,
  output logic TX_EOI_OUT,
  input wire logic TX_READY_IN
);
  // ==========================================================
  // state and decoded helpers
  mrf_st_t s_r;
  mrf_st_t s_nxt;
  logic [7:0] fbyte;
  logic flast;
  logic bin_mode;
  logic list_mode;
  logic [2:0] nf;
  logic [3:0] np;
  logic [8:0] len;
  logic [1:0] ndig;
  logic signed [4:0] aux;

  // trigger state as a two-bit status code
  function automatic logic [1:0] trig_code(input mrf_trig_t t);
    unique case (t)
      TR_IDLE: trig_code = 2'h0;
      TR_WAIT: trig_code = 2'h1;
      TR_MEAS: trig_code = 2'h2;
      default: trig_code = 2'h3;
    endcase
  endfunction : trig_code

  // access decode, used for both read and write paths
  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = (a == b);
  endfunction : hit

  // ==========================================================
  // message geometry
  assign bin_mode = s_r.ctrl[`MRF_B_BINARY];
  assign list_mode = s_r.ctrl[`MRF_B_LIST];
  // list and comparator both add a fourth field per point
  assign nf = (list_mode || s_r.ctrl[`MRF_B_COMP]) ? 3'd4 : 3'd3;
  // out-of-range point counts are clamped so the index never runs away
  assign np = !list_mode ? 4'h1 :
              (s_r.npts == 4'h0) ? 4'h1 :
              (s_r.npts > `MRF_MAX_PTS) ? `MRF_MAX_PTS : s_r.npts;
  assign len = 9'({np, 3'b000} * nf);
  assign ndig = (len >= 9'd100) ? 2'd3 : 2'd2;
  // list sweep carries the verdict if MRF_B_LCOMP is set, else zero; single shots the bin number
  assign aux = list_mode ?
               (s_r.ctrl[`MRF_B_LCOMP] ?
                {{3{VERDICT_IN[1]}}, VERDICT_IN} : 5'sd0) :
               $signed({1'b0, BIN_IN});

  // ==========================================================
  // field character generator
  mrf_field_char u_char
  (
    .BIN_MODE_IN(bin_mode),
    .FSEL_IN(s_r.fld),
    .IDX_IN(s_r.idx),
    .PRI_DEC_IN(PRI_DEC_IN),
    .SEC_DEC_IN(SEC_DEC_IN),
    .PRI_DBL_IN(PRI_DBL_IN),
    .SEC_DBL_IN(SEC_DBL_IN),
    .STATUS_IN(STATUS_IN),
    .AUX_IN(aux),
    .BYTE_OUT(fbyte),
    .LAST_OUT(flast)
  );

  // ==========================================================
  // next state
  always_comb
  begin
    logic wr;
    logic rd_setup;
    logic [31:0] cmd;
    logic load;
    logic [7:0] cur;
    logic lastfld;
    logic lastpt;
    logic [3:0] dg;
    logic fetch_ok;
    s_nxt = s_r;
    cur = `MRF_CH_NUL;
    dg = 4'h0;
    wr = PSEL_IN && PENABLE_IN && PWRITE_IN;
    rd_setup = PSEL_IN && !PENABLE_IN;
    cmd = (wr && hit(PADDR_IN, `MRF_A_CMD)) ? PWDATA_IN : 32'h0;
    s_nxt.mstart = 1'b0;
    // register writes land at the access edge
    if (wr && hit(PADDR_IN, `MRF_A_CTRL))
      s_nxt.ctrl = PWDATA_IN[4:0];
    if (wr && hit(PADDR_IN, `MRF_A_NPTS))
      s_nxt.npts = PWDATA_IN[3:0];
    // read data is prepared in the setup cycle so the answer is a flop
    if (rd_setup)
    begin
      s_nxt.slverr = !(hit(PADDR_IN, `MRF_A_CTRL) ||
                       hit(PADDR_IN, `MRF_A_CMD) ||
                       hit(PADDR_IN, `MRF_A_STAT) ||
                       hit(PADDR_IN, `MRF_A_NPTS));
      s_nxt.rdata = 32'h0;
      if (hit(PADDR_IN, `MRF_A_CTRL))
        s_nxt.rdata[4:0] = s_r.ctrl;
      if (hit(PADDR_IN, `MRF_A_NPTS))
        s_nxt.rdata[3:0] = s_r.npts;
      if (hit(PADDR_IN, `MRF_A_STAT))
      begin
        s_nxt.rdata[1:0] = trig_code(s_r.trig);
        s_nxt.rdata[`MRF_S_HAVE] = s_r.have;
        s_nxt.rdata[`MRF_S_BUSY] = (s_r.ph != PH_IDLE) || s_r.txv;
        s_nxt.rdata[`MRF_S_ERR] = s_r.err;
      end
    end
    // error flag: write one clears, a new error in the same cycle wins
    if (wr && hit(PADDR_IN, `MRF_A_STAT) && PWDATA_IN[`MRF_S_ERR])
      s_nxt.err = 1'b0;

    // ---------------- trigger sequencing
    unique case (s_r.trig)
      TR_IDLE:
      begin
        // continuous with nothing left to read restarts on its own
        if (cmd[`MRF_C_INIT] ||
            (s_r.ctrl[`MRF_B_CONT] && !s_r.have && s_r.ph == PH_IDLE))
          s_nxt.trig = TR_WAIT;
      end
      TR_WAIT:
      begin
        if (cmd[`MRF_C_TRIG] || TRIG_IN)
        begin
          s_nxt.trig = TR_MEAS;
          s_nxt.mstart = 1'b1;
          s_nxt.have = 1'b0;
        end
      end
      TR_MEAS:
      begin
        if (MEAS_DONE_IN)
        begin
          s_nxt.trig = TR_IDLE;
          s_nxt.have = 1'b1;
        end
      end
    endcase

    // ---------------- fetch request
    fetch_ok = (s_r.trig == TR_IDLE) && (s_r.ph == PH_IDLE) && !s_r.txv;
    if (cmd[`MRF_C_FETCH] && fetch_ok)
    begin
      if (!s_r.have)
        s_nxt.err = 1'b1;
      else
      begin
        s_nxt.ph = bin_mode ? PH_HASH : PH_FLD;
        s_nxt.pt = 4'h0;
        s_nxt.fld = 2'd0;
        s_nxt.idx = 4'h0;
      end
    end

    // ---------------- byte of the current phase
    if (s_r.idx == 4'h0 && ndig == 2'd3)
      dg = 4'(len / 9'd100);
    else if ((s_r.idx == 4'h0) || (s_r.idx == 4'h1 && ndig == 2'd3))
      dg = 4'((len / 9'd10) % 9'd10);
    else
      dg = 4'(len % 9'd10);
    unique case (s_r.ph)
      PH_HASH: cur = `MRF_CH_HASH;
      PH_NDIG: cur = `MRF_CH_ZERO | {6'h0, ndig};
      PH_LEN: cur = `MRF_CH_ZERO | {4'h0, dg};
      PH_COMMA: cur = `MRF_CH_COMMA;
      PH_ZERO: cur = `MRF_CH_NUL;
      PH_LF: cur = `MRF_CH_LF;
      default: cur = fbyte;
    endcase

    // output flop takes a byte whenever it is empty or being drained
    load = (s_r.ph != PH_IDLE) && (!s_r.txv || TX_READY_IN);
    if (s_r.txv && TX_READY_IN)
      s_nxt.txv = 1'b0;
    if (load)
    begin
      s_nxt.txd = cur;
      s_nxt.txv = 1'b1;
      s_nxt.txe = (s_r.ph == PH_LF);
    end
    lastfld = ({1'b0, s_r.fld} == nf - 3'd1);
    lastpt = (s_r.pt == np - 4'h1);

    // ---------------- sequencer advance
    if (load)
    begin
      unique case (s_r.ph)
        PH_HASH: s_nxt.ph = PH_NDIG;
        PH_NDIG:
        begin
          s_nxt.ph = PH_LEN;
          s_nxt.idx = 4'h0;
        end
        PH_LEN:
        begin
          s_nxt.idx = s_r.idx + 4'h1;
          if (s_r.idx == {2'b00, ndig} - 4'h1)
          begin
            s_nxt.ph = PH_FLD;
            s_nxt.idx = 4'h0;
          end
        end
        PH_FLD:
        begin
          s_nxt.idx = s_r.idx + 4'h1;
          if (flast)
          begin
            s_nxt.idx = 4'h0;
            if (lastfld && lastpt)
              s_nxt.ph = bin_mode ? PH_ZERO : PH_LF;
            else
            begin
              // binary fields butt together, ascii ones take a comma
              s_nxt.ph = bin_mode ? PH_FLD : PH_COMMA;
              s_nxt.fld = lastfld ? 2'd0 : s_r.fld + 2'd1;
              if (lastfld)
                s_nxt.pt = s_r.pt + 4'h1;
            end
          end
        end
        PH_COMMA: s_nxt.ph = PH_FLD;
        PH_ZERO: s_nxt.ph = PH_LF;
        PH_LF:
        begin
          s_nxt.ph = PH_IDLE;
          if (s_r.ctrl[`MRF_B_CONT])
            s_nxt.trig = TR_WAIT;
        end
        default: s_nxt.ph = PH_IDLE;
      endcase
    end

    // ---------------- abort overrides everything in flight
    if (cmd[`MRF_C_ABORT])
    begin
      s_nxt.trig = TR_IDLE;
      s_nxt.have = 1'b0;
      s_nxt.ph = PH_IDLE;
      s_nxt.txv = 1'b0;
      s_nxt.txe = 1'b0;
      s_nxt.mstart = 1'b0;
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge MCLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
    begin
      s_r <= '0;
      s_r.trig <= TR_IDLE;
      s_r.ph <= PH_IDLE;
      s_r.ctrl <= `MRF_CTRL_RST;
      s_r.npts <= `MRF_NPTS_RST;
    end
    else
      s_r <= s_nxt;
  end

  // ==========================================================
  // outputs
  assign PRDATA_OUT = s_r.rdata;
  assign PREADY_OUT = 1'b1;
  assign PSLVERR_OUT = s_r.slverr && PSEL_IN && PENABLE_IN;
  assign MEAS_START_OUT = s_r.mstart;
  assign PT_IDX_OUT = s_r.pt;
  assign TX_DATA_OUT = s_r.txd;
  assign TX_VALID_OUT = s_r.txv;
  assign TX_EOI_OUT = s_r.txe && s_r.txv;
endmodule : mrf_formatter
`default_nettype wire

// ---- testbench/mrf_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// port checker for the formatter
module mrf_monitor (
  // clock and reset
  input wire logic MCLK_IN,
  input wire logic RSTN_IN,
  // apb
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  input wire logic PSLVERR_OUT,
  // engine and stream
  input wire logic MEAS_START_OUT,
  input wire logic [3:0] PT_IDX_OUT,
  input wire logic [7:0] TX_DATA_OUT,
  input wire logic TX_VALID_OUT,
  input wire logic TX_EOI_OUT,
  input wire logic TX_READY_IN
);
  default clocking @(posedge MCLK_IN); endclocking
  default disable iff (!RSTN_IN);
  // access decode; an abort may withdraw a byte still on offer
  wire logic acc = PSEL_IN && PENABLE_IN;
  wire logic bad = PADDR_IN > 8'h0C || PADDR_IN[1:0] != 2'h0;
  wire logic abt = acc && PWRITE_IN && PADDR_IN == 8'h04 && PWDATA_IN[1];
  slverr_unmapped_a: assert property (acc && bad |-> PSLVERR_OUT)
    else $error("no slverr on unmapped access");
  slverr_mapped_a: assert property (acc && !bad |-> !PSLVERR_OUT)
    else $error("slverr on mapped access");
  tx_hold_a: assert property (TX_VALID_OUT && !TX_READY_IN && !abt |=>
    TX_VALID_OUT && $stable(TX_DATA_OUT)) else $error("byte not held");
  eoi_linefeed_a: assert property (TX_EOI_OUT |->
    TX_VALID_OUT && TX_DATA_OUT == 8'h0A) else $error("eoi without lf");
  eoi_closes_a: assert property (
    TX_VALID_OUT && TX_READY_IN && TX_EOI_OUT |=> !TX_VALID_OUT)
    else $error("byte after terminator");
  start_pulse_a: assert property (MEAS_START_OUT |=> !MEAS_START_OUT)
    else $error("start pulse too long");
  abort_stops_a: assert property (abt |=> !TX_VALID_OUT [*2])
    else $error("output after abort");
  pt_range_a: assert property (PT_IDX_OUT < 4'hA)
    else $error("point index out of range");
  // main scenarios
  cover property (TX_EOI_OUT && TX_READY_IN);
  cover property (TX_VALID_OUT && !TX_READY_IN);
  cover property (abt && TX_VALID_OUT);
endmodule : mrf_monitor
bind mrf_formatter mrf_monitor mrf_monitor_inst (.MCLK_IN, .RSTN_IN,
  .PSEL_IN, .PENABLE_IN, .PWRITE_IN, .PADDR_IN, .PWDATA_IN, .PSLVERR_OUT,
  .MEAS_START_OUT, .PT_IDX_OUT, .TX_DATA_OUT, .TX_VALID_OUT, .TX_EOI_OUT,
  .TX_READY_IN);
`default_nettype wire

// ---- testbench/mrf_ctl_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// controller reading the talker byte stream
module mrf_ctl_model (
  // clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // talker stream
  input wire logic [7:0] data_in,
  input wire logic valid_in,
  input wire logic eoi_in,
  input wire logic slow_in,
  output logic ready_out,
  // bytes taken, eoi in the top bit
  output logic got_out,
  output logic [8:0] got_word_out
);
  logic [7:0] pat_r;
  // slow mode stalls on a shifting pattern so that holds get exercised
  assign ready_out = !slow_in || pat_r[0];
  // eoi is passed on beside each byte; the zero pad is taken and passed on like any other byte
  always_ff @(posedge clk_in or negedge rstn_in)
    if (!rstn_in)
    begin
      pat_r <= 8'hA5;
      got_out <= 1'b0;
      got_word_out <= 9'h000;
    end
    else
    begin
      pat_r <= {pat_r[6:0], pat_r[7] ^ pat_r[5]};
      got_out <= valid_in && ready_out;
      got_word_out <= {eoi_in, data_in};
    end
endmodule : mrf_ctl_model
`default_nettype wire

// ---- testbench/test_mrf_formatter.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "mrf_cfg.svh"
// ==========================================
// self-checking bench for the formatter
module test_mrf_formatter;
  localparam logic [63:0] OVF_B = $realtobits(9.9E37);
  localparam logic [33:0] OVF_D = {1'b0, 24'h990000, 1'b0, 8'h37};
  localparam logic [4:0] CTAB [4] = '{5'h14, 5'h04, 5'h15, 5'h08};
  localparam int NTAB [4] = '{3, 0, 12, 1};
  logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic trig = 1'b0, done = 1'b0, slow = 1'b0, se_v, got;
  logic pready, pslverr, mstart, txv, txe, rdy;
  logic [7:0] paddr = 8'h00, txd;
  logic [31:0] pwdata = 32'h0, prdata, rd_v, seed = 32'd61803;
  logic [3:0] pt;
  logic [8:0] gw;
  logic [8:0] exp_q [$];
  logic [33:0] pd [10], sd [10];
  logic [63:0] pdb [10], sdb [10];
  logic signed [2:0] st [10];
  logic [3:0] bn [10];
  logic signed [1:0] vd [10];
  int n_fail = 0, cmp_count = 0, cyc = 0;
  // design and controller; point data follows the requested index
  mrf_formatter mrf_formatter_inst (.MCLK_IN(clk), .RSTN_IN(rstn),
    .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr),
    .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
    .PSLVERR_OUT(pslverr), .TRIG_IN(trig), .MEAS_DONE_IN(done),
    .MEAS_START_OUT(mstart), .PT_IDX_OUT(pt), .PRI_DEC_IN(pd[pt]),
    .SEC_DEC_IN(sd[pt]), .PRI_DBL_IN(pdb[pt]), .SEC_DBL_IN(sdb[pt]),
    .STATUS_IN(st[pt]), .BIN_IN(bn[pt]), .VERDICT_IN(vd[pt]),
    .TX_DATA_OUT(txd), .TX_VALID_OUT(txv), .TX_EOI_OUT(txe),
    .TX_READY_IN(rdy));
  mrf_ctl_model mrf_ctl_model_inst (.clk_in(clk), .rstn_in(rstn),
    .data_in(txd), .valid_in(txv), .eoi_in(txe), .slow_in(slow),
    .ready_out(rdy), .got_out(got), .got_word_out(gw));
  // clock
  initial
    forever #5 clk = ~clk;
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  // random decimal value with legal digits
  function automatic logic [33:0] dec();
    logic [33:0] v;
    v = 34'(rnd());
    for (int k = 0; k < 8; k++)
      v[(k < 2 ? 4 * k : 4 * k + 1) +: 4] = 4'(rnd() % 10);
    return v;
  endfunction : dec
  task automatic check(input string nm, input logic [63:0] e, s);
    cmp_count++;
    if (s !== e)
    begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask : check
  task automatic summarize();
    if (n_fail == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : summarize
  // one transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd_v = prdata;
    se_v = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic rdc(input string nm, input logic [7:0] a,
    input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(nm, e, rd_v);
  endtask : rdc
  task automatic pb8(input logic [7:0] b);
    exp_q.push_back({1'b0, b});
  endtask : pb8
  task automatic pasc(input logic [33:0] v);
    pb8(v[33] ? 8'h2D : 8'h2B);
    pb8({4'h3, v[32:29]});
    pb8(8'h2E);
    for (int j = 1; j < 6; j++)
      pb8({4'h3, v[29 - 4 * j +: 4]});
    pb8(8'h45);
    pb8(v[8] ? 8'h2D : 8'h2B);
    pb8({4'h3, v[7:4]});
    pb8({4'h3, v[3:0]});
  endtask : pasc
  task automatic psgn(input int x);
    pb8(x < 0 ? 8'h2D : 8'h2B);
    if (x > 9)
      pb8(8'h31);
    pb8(8'(48 + (x < 0 ? -x : x) % 10));
  endtask : psgn
  task automatic pdbl(input logic [63:0] v);
    for (int i = 7; i >= 0; i--)
      pb8(v[8 * i +: 8]);
  endtask : pdbl
  // note every byte of one response in sending order
  task automatic note_msg(input logic [4:0] c, input int n);
    int nf, len, x;
    logic rep;
    nf = c[2] || c[1] ? 4 : 3;
    len = nf * 8 * n;
    if (c[0])
    begin
      pb8(8'h23);
      pb8(len < 100 ? 8'h32 : 8'h33);
      if (len > 99)
        pb8(8'(48 + len / 100));
      pb8(8'(48 + len / 10 % 10));
      pb8(8'(48 + len % 10));
    end
    for (int p = 0; p < n; p++)
    begin
      rep = st[p] == -1 || st[p] == 1 || st[p] == 2;
      x = c[2] ? 0 : bn[p];
      if (c[2] && c[4])
        x = vd[p];
      if (c[0])
      begin
        pdbl(rep ? OVF_B : pdb[p]);
        pdbl(rep ? OVF_B : sdb[p]);
        pdbl($realtobits(real'(st[p])));
        if (nf == 4)
          pdbl($realtobits(real'(x)));
      end
      else
      begin
        if (p > 0)
          pb8(8'h2C);
        pasc(rep ? OVF_D : pd[p]);
        pb8(8'h2C);
        pasc(rep ? OVF_D : sd[p]);
        pb8(8'h2C);
        psgn(st[p]);
        if (nf == 4)
        begin
          pb8(8'h2C);
          psgn(x);
        end
      end
    end
    if (c[0])
      pb8(8'h00);
    exp_q.push_back(9'h10A);
  endtask : note_msg
  // fresh point data; status walks through six of its eight codes, bin through 0 to 10, verdict through -1 to 1
  task automatic fill(input int r);
    for (int p = 0; p < 10; p++)
    begin
      pd[p] <= dec();
      sd[p] <= dec();
      pdb[p] <= {rnd(), rnd()};
      sdb[p] <= {rnd(), rnd()};
      st[p] <= 3'((r + p) % 6 - 1);
      bn[p] <= 4'(r / 2 % 11);
      vd[p] <= 2'((r + p) % 3 - 1);
    end
  endtask : fill
  // one measurement, fetched and compared; ab aborts it mid message
  task automatic run(input int r, input logic ab);
    logic [4:0] c;
    int m, n, k;
    c = r[0] ? CTAB[r / 2 % 4] : (r[1] ? 5'h03 : 5'h02);
    m = r[0] ? NTAB[r / 2 % 4] : 1;
    n = !c[2] || m == 0 ? 1 : (m > 10 ? 10 : m);
    k = 0;
    slow <= r[2];
    fill(r);
    apb(1'b1, `MRF_A_CTRL, 32'(c));
    apb(1'b1, `MRF_A_NPTS, 32'(m));
    apb(1'b1, `MRF_A_CMD, 32'h1 << `MRF_C_INIT);
    trig <= r[0];
    if (!r[0])
      apb(1'b1, `MRF_A_CMD, 32'h1 << `MRF_C_TRIG);
    while (mstart !== 1'b1 && k++ < 20)
      @(posedge clk);
    check("start", 64'h1, 64'(k < 21));
    trig <= 1'b0;
    repeat (2) @(posedge clk);
    done <= 1'b1;
    @(posedge clk);
    done <= 1'b0;
    rdc("done state", `MRF_A_STAT, 32'h4);
    note_msg(c, n);
    apb(1'b1, `MRF_A_CMD, 32'h1 << `MRF_C_FETCH);
    if (ab)
    begin
      repeat (30) @(posedge clk);
      apb(1'b1, `MRF_A_CMD, 32'h1 << `MRF_C_ABORT);
      repeat (2) @(posedge clk);
      exp_q.delete();
      rdc("abort state", `MRF_A_STAT, 32'h0);
      apb(1'b1, `MRF_A_CMD, 32'h1 << `MRF_C_FETCH);
      rdc("stale fetch", `MRF_A_STAT, 32'h10);
      apb(1'b1, `MRF_A_STAT, 32'h10);
      return;
    end
    while (exp_q.size() > 0 && k++ < 3000)
      @(posedge clk);
    @(posedge clk);
    check("left over", 64'h0, 64'(exp_q.size()));
    rdc("read state", `MRF_A_STAT, c[3] ? 32'h5 : 32'h4);
  endtask : run
  // take the oldest note for every byte the controller accepts
  always @(posedge clk)
    if (got)
      check("tx", exp_q.size() ? exp_q.pop_front() : 9'h1FF, gw);
  // cut a hang short, far above the longest run
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      n_fail++;
      summarize();
    end
  end
  // main sequence
  initial
  begin
    fill(0);
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    rdc("ctrl reset", `MRF_A_CTRL, 32'h0);
    rdc("npts reset", `MRF_A_NPTS, 32'h1);
    rdc("stat reset", `MRF_A_STAT, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    check("unmapped", 64'h1, 64'(se_v));
    apb(1'b1, `MRF_A_CMD, 32'h1 << `MRF_C_FETCH);
    rdc("empty fetch", `MRF_A_STAT, 32'h10);
    apb(1'b1, `MRF_A_STAT, 32'h10);
    for (int r = 0; r < 22; r++)
      run(r, 1'b0);
    run(5, 1'b1);
    summarize();
  end
endmodule : test_mrf_formatter
`default_nettype wire
